// ===== design/pmh_map.svh
// Functional notes
// - code 0x0030 sets coarse level 0..5 from payload byte 0 and saves it
// - code 0x0031 steps the coarse level up one and saves it
// - code 0x0032 steps the coarse level down one and saves it
// - code 0x0033 reapplies the saved level, which is 0% if never saved
// - code 0x0034 forces 0% and keeps the saved level
// - code 0x0035 changes nothing and only reports the applied and saved levels
// - code 0x0036 acts as restore when off, as off when on
// - code 0x0037 sets fine duty 0..256, no save, echoes it in bits 8-0
// - code 0x0038 returns last fine duty, zero if never set
// - coarse answers carry applied level in byte 0, saved level in byte 1
// - code 0x0040 byte 0 enables report on input zero falling edge
// - config bytes 2-1 give report interval in 5 s units, 0 disables
// - config sender becomes the concentrator for all later reports
// - autonomous reports use code 0x0041
// - report bytes: input states, output states, two 10-bit conversions
// - metering config may be broadcast; every node applies it
// - edge-only nodes survive power-off while enable is low
// - first report delayed by an offset from own node address
// - status lamp pulses once per successfully sent report
// - profiles: 0 none, 1 motor, 2 dimming, 3 metering; duty only in 2
// - plain output set and clear refused in motor or dimming profile
`ifndef PMH_MAP_SVH
`define PMH_MAP_SVH
// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define PMH_OFF_CTRL 8'h00
`define PMH_OFF_CMD 8'h04
`define PMH_OFF_PAY_LO 8'h08
`define PMH_OFF_PAY_HI 8'h0c
`define PMH_OFF_ANS_LO 8'h10
`define PMH_OFF_ANS_HI 8'h14
`define PMH_OFF_STATUS 8'h18
`define PMH_OFF_NODE 8'h1c
`define PMH_OFF_REP_HDR 8'h20
`define PMH_OFF_REP_LO 8'h24
`define PMH_OFF_REP_HI 8'h28
`define PMH_OFF_REP_ACK 8'h2c
`define PMH_OFF_METER 8'h30
// ----------------------------------------
// fields and codes
// ----------------------------------------
`define PMH_CTRL_GO 8
`define PMH_ST_ANS 0
`define PMH_ST_REFUSED 1
`define PMH_CMD_IO_SET 16'h0010
`define PMH_CMD_IO_CLR 16'h0011
`define PMH_CMD_SET 16'h0030
`define PMH_CMD_UP 16'h0031
`define PMH_CMD_DOWN 16'h0032
`define PMH_CMD_ON 16'h0033
`define PMH_CMD_OFF 16'h0034
`define PMH_CMD_READ 16'h0035
`define PMH_CMD_TOGGLE 16'h0036
`define PMH_CMD_FINE 16'h0037
`define PMH_CMD_RD_FINE 16'h0038
`define PMH_CMD_METER 16'h0040
`define PMH_CMD_REPORT 16'h0041
`define PMH_PROF_NONE 2'h0
`define PMH_PROF_MOTOR 2'h1
`define PMH_PROF_DIM 2'h2
`define PMH_PROF_METER 2'h3
`define PMH_LVL_MAX 3'h5
`define PMH_FINE_FULL 9'h100
`define PMH_RESP_OKAY 2'h0
`define PMH_RESP_DECERR 2'h3
// ----------------------------------------
// timing
// ----------------------------------------
`define PMH_CLK_HZ 125000000
`define PMH_UNIT_S 5
`define PMH_SLOT_MS 10
`define PMH_BLINK_MS 50
`endif

// ===== design/pmh_pkg.sv
package pmh_pkg;
  // ----------------------------------------
  // report sequencer states
  // ----------------------------------------
  typedef enum logic [1:0] {RS_OFF, RS_HOLDOFF, RS_RUN} pmh_rep_t;

  // modulator state
  typedef struct packed {
    logic [7:0] cnt;
    logic out;
  } pmh_pwm_t;

  // whole state of the command handler
  typedef struct packed {
    logic aw_got;
    logic [7:0] awaddr;
    logic w_got;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic [1:0] profile;
    logic [31:0] cmd;
    logic [31:0] pay_lo;
    logic [31:0] pay_hi;
    logic [31:0] ans_lo;
    logic [31:0] ans_hi;
    logic ans_valid;
    logic refused;
    logic [7:0] node;
    logic [2:0] level;
    logic [2:0] saved;
    logic on;
    logic fine_act;
    logic [8:0] fine;
    logic nvm_we;
    logic gout0;
    logic gout1;
    logic edge_en;
    logic [15:0] interval;
    logic [7:0] conc;
    pmh_rep_t rs;
    logic [31:0] unit_cnt;
    logic [15:0] per_cnt;
    logic [7:0] slots;
    logic [31:0] slot_cnt;
    logic want;
    logic rep_pend;
    logic [31:0] rep_lo;
    logic [31:0] rep_hi;
    logic led;
    logic [31:0] led_cnt;
    logic in0_s1;
    logic in0_s2;
    logic in0_d;
    logic in1_s1;
    logic in1_s2;
  } pmh_state_t;
endpackage : pmh_pkg

// ===== design/pmh_pwm_if.sv
`timescale 1ns/100ps
`default_nettype none
// duty request from the handler, modulated pin back from the generator
interface pmh_pwm_if;
  logic [8:0] duty;
  logic use_pwm;
  logic io_level;
  logic pin;
  modport handler (output duty, output use_pwm, output io_level, input pin);
  modport gen (input duty, input use_pwm, input io_level, output pin);
endinterface : pmh_pwm_if
`default_nettype wire

// ===== design/pmh_pwm.sv
`timescale 1ns/100ps
`default_nettype none
module pmh_pwm (
  input wire logic clk, // system clock
  input wire logic rst, // async reset, high
  pmh_pwm_if.gen pw // duty in, pin out
);
  pmh_pkg::pmh_pwm_t r_reg;
  pmh_pkg::pmh_pwm_t r_next;

  // free 256-count period; cnt < duty so 256 never drops low
  always_comb begin
    r_next = r_reg;
    r_next.cnt = r_reg.cnt + 8'h01;
    if (pw.use_pwm) begin
      r_next.out = ({1'b0, r_reg.cnt} < pw.duty);
    end else begin
      r_next.out = pw.io_level;
    end
  end

  // state register
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      r_reg <= '0;
    end else begin
      r_reg <= r_next;
    end
  end

  assign pw.pin = r_reg.out;
endmodule : pmh_pwm
`default_nettype wire

// ===== design/pmh_top.sv
// Register access over AXI4-Lite and the placing of the registers were chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none
`include "pmh_map.svh"
module pmh_top #(
  parameter int UNIT_CYCLES = `PMH_UNIT_S * `PMH_CLK_HZ, // one 5 s interval unit
  parameter int SLOT_CYCLES = `PMH_SLOT_MS * (`PMH_CLK_HZ / 1000), // per-address offset
  parameter int BLINK_CYCLES = `PMH_BLINK_MS * (`PMH_CLK_HZ / 1000) // lamp pulse
) (
  input wire logic MCLK, // system clock
  input wire logic RESET, // async reset, high
  input wire logic [7:0] S_AXI_AWADDR, // write address
  input wire logic S_AXI_AWVALID, // write address valid
  output logic S_AXI_AWREADY, // write address ready
  input wire logic [31:0] S_AXI_WDATA, // write data
  input wire logic [3:0] S_AXI_WSTRB, // byte enables
  input wire logic S_AXI_WVALID, // write data valid
  output logic S_AXI_WREADY, // write data ready
  output logic [1:0] S_AXI_BRESP, // write response
  output logic S_AXI_BVALID, // write response valid
  input wire logic S_AXI_BREADY, // write response ready
  input wire logic [7:0] S_AXI_ARADDR, // read address
  input wire logic S_AXI_ARVALID, // read address valid
  output logic S_AXI_ARREADY, // read address ready
  output logic [31:0] S_AXI_RDATA, // read data
  output logic [1:0] S_AXI_RRESP, // read response
  output logic S_AXI_RVALID, // read data valid
  input wire logic S_AXI_RREADY, // read data ready
  input wire logic GENERAL_INPUT_ZERO, // pin, falling edge may trigger report
  input wire logic GENERAL_INPUT_ONE, // pin, reported only
  input wire logic [9:0] CONV_ZERO, // conversion result 0, same clock
  input wire logic [9:0] CONV_ONE, // conversion result 1, same clock
  output logic GENERAL_OUTPUT_ZERO, // dimming output or plain output
  output logic GENERAL_OUTPUT_ONE, // plain output
  output logic NVM_WRITE, // one-cycle save strobe
  output logic [2:0] NVM_LEVEL, // level being saved
  output logic REPORT_PENDING, // report waiting for the radio
  output logic STATUS_LAMP // lamp pulse after a sent report
);
  pmh_pkg::pmh_state_t s_reg;
  pmh_pkg::pmh_state_t s_next;
  pmh_pwm_if pif ();

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  // coarse level to fine counts: 0, 1, 4, 16, 64, 256
  function automatic logic [8:0] lvl_duty(input logic [2:0] l);
    case (l)
      3'h1: lvl_duty = 9'h001;
      3'h2: lvl_duty = 9'h004;
      3'h3: lvl_duty = 9'h010;
      3'h4: lvl_duty = 9'h040;
      3'h5: lvl_duty = `PMH_FINE_FULL;
      default: lvl_duty = 9'h000;
    endcase
  endfunction : lvl_duty

  // byte-lane merge honouring write strobes
  function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] n,
                                        input logic [3:0] st);
    merge = o;
    for (int i = 0; i < 4; i++) begin
      if (st[i]) begin
        merge[8*i +: 8] = n[8*i +: 8];
      end
    end
  endfunction : merge

  // read mux; unmapped offsets answer zero with a decode error
  function automatic logic [33:0] rd_mux(input pmh_pkg::pmh_state_t s, input logic [7:0] a);
    rd_mux = {`PMH_RESP_OKAY, 32'h0000_0000};
    case (a)
      `PMH_OFF_CTRL: rd_mux[31:0] = {30'h0, s.profile};
      `PMH_OFF_CMD: rd_mux[31:0] = s.cmd;
      `PMH_OFF_PAY_LO: rd_mux[31:0] = s.pay_lo;
      `PMH_OFF_PAY_HI: rd_mux[31:0] = s.pay_hi;
      `PMH_OFF_ANS_LO: rd_mux[31:0] = s.ans_lo;
      `PMH_OFF_ANS_HI: rd_mux[31:0] = s.ans_hi;
      `PMH_OFF_STATUS: rd_mux[31:0] = {20'h0, s.on, s.saved, 1'b0, s.level,
                                       s.fine_act, s.rep_pend, s.refused, s.ans_valid};
      `PMH_OFF_NODE: rd_mux[31:0] = {24'h0, s.node};
      `PMH_OFF_REP_HDR: rd_mux[31:0] = {8'h0, s.conc, `PMH_CMD_REPORT};
      `PMH_OFF_REP_LO: rd_mux[31:0] = s.rep_lo;
      `PMH_OFF_REP_HI: rd_mux[31:0] = s.rep_hi;
      `PMH_OFF_REP_ACK: rd_mux[31:0] = 32'h0000_0000;
      `PMH_OFF_METER: rd_mux[31:0] = {s.interval, 15'h0, s.edge_en};
      default: rd_mux[33:32] = `PMH_RESP_DECERR;
    endcase
  endfunction : rd_mux

  // ----------------------------------------
  // next-state logic
  // ----------------------------------------
  always_comb begin
    logic do_wr;
    logic go;
    logic ack;
    logic fall;
    logic tick;
    logic trig;
    logic [2:0] lv;
    logic [15:0] code;
    logic [33:0] rd;
    do_wr = 1'b0;
    go = 1'b0;
    ack = 1'b0;
    fall = 1'b0;
    tick = 1'b0;
    trig = 1'b0;
    lv = 3'h0;
    code = s_reg.cmd[15:0];
    rd = '0;
    s_next = s_reg;
    s_next.nvm_we = 1'b0;

    // pin synchronisers; edge detect looks only at the second stage
    s_next.in0_s1 = GENERAL_INPUT_ZERO;
    s_next.in0_s2 = s_reg.in0_s1;
    s_next.in0_d = s_reg.in0_s2;
    s_next.in1_s1 = GENERAL_INPUT_ONE;
    s_next.in1_s2 = s_reg.in1_s1;
    fall = s_reg.in0_d & ~s_reg.in0_s2;

    // write channel: address and data taken in either order
    if (S_AXI_AWVALID && !s_reg.aw_got && !s_reg.bvalid) begin
      s_next.aw_got = 1'b1;
      s_next.awaddr = S_AXI_AWADDR;
    end
    if (S_AXI_WVALID && !s_reg.w_got && !s_reg.bvalid) begin
      s_next.w_got = 1'b1;
      s_next.wdata = S_AXI_WDATA;
      s_next.wstrb = S_AXI_WSTRB;
    end
    if (s_reg.bvalid && S_AXI_BREADY) begin
      s_next.bvalid = 1'b0;
    end
    if (s_reg.aw_got && s_reg.w_got && !s_reg.bvalid) begin
      do_wr = 1'b1;
      s_next.aw_got = 1'b0;
      s_next.w_got = 1'b0;
      s_next.bvalid = 1'b1;
      s_next.bresp = `PMH_RESP_OKAY;
    end

    // register writes
    if (do_wr) begin
      case (s_reg.awaddr)
        `PMH_OFF_CTRL: begin
          if (s_reg.wstrb[0]) begin
            s_next.profile = s_reg.wdata[1:0];
          end
          go = s_reg.wstrb[1] & s_reg.wdata[`PMH_CTRL_GO];
        end
        `PMH_OFF_CMD: s_next.cmd = merge(s_reg.cmd, s_reg.wdata, s_reg.wstrb);
        `PMH_OFF_PAY_LO: s_next.pay_lo = merge(s_reg.pay_lo, s_reg.wdata, s_reg.wstrb);
        `PMH_OFF_PAY_HI: s_next.pay_hi = merge(s_reg.pay_hi, s_reg.wdata, s_reg.wstrb);
        `PMH_OFF_STATUS: begin
          if (s_reg.wstrb[0] && s_reg.wdata[`PMH_ST_ANS]) begin
            s_next.ans_valid = 1'b0;
          end
        end
        `PMH_OFF_NODE: begin
          if (s_reg.wstrb[0]) begin
            s_next.node = s_reg.wdata[7:0];
          end
        end
        `PMH_OFF_REP_ACK: ack = s_reg.wstrb[0] & s_reg.wdata[0] & s_reg.rep_pend;
        default: s_next.bresp = `PMH_RESP_DECERR;
      endcase
    end

    // read channel; one read at a time
    if (s_reg.rvalid && S_AXI_RREADY) begin
      s_next.rvalid = 1'b0;
    end
    if (S_AXI_ARVALID && !s_reg.rvalid) begin
      rd = rd_mux(s_reg, S_AXI_ARADDR);
      s_next.rvalid = 1'b1;
      s_next.rdata = rd[31:0];
      s_next.rresp = rd[33:32];
    end

    // command execution; duty commands only in the dimming profile
    if (go) begin
      s_next.ans_valid = 1'b1;
      s_next.refused = 1'b0;
      s_next.ans_lo = 32'h0000_0000;
      s_next.ans_hi = 32'h0000_0000;
      if (code >= `PMH_CMD_SET && code <= `PMH_CMD_RD_FINE
          && s_reg.profile != `PMH_PROF_DIM) begin
        s_next.refused = 1'b1;
      end else begin
        case (code)
          `PMH_CMD_SET: begin
            if (s_reg.pay_lo[7:0] > {5'h0, `PMH_LVL_MAX}) begin
              s_next.refused = 1'b1;
            end else begin
              lv = s_reg.pay_lo[2:0];
              s_next.level = lv;
              s_next.saved = lv;
              s_next.on = 1'b1;
              s_next.fine_act = 1'b0;
              s_next.nvm_we = 1'b1;
            end
          end
          `PMH_CMD_UP, `PMH_CMD_DOWN: begin
            lv = s_reg.on ? s_reg.level : s_reg.saved;
            if (code == `PMH_CMD_UP) begin
              lv = (lv == `PMH_LVL_MAX) ? lv : lv + 3'h1;
            end else begin
              lv = (lv == 3'h0) ? lv : lv - 3'h1;
            end
            s_next.level = lv;
            s_next.saved = lv;
            s_next.on = 1'b1;
            s_next.fine_act = 1'b0;
            s_next.nvm_we = 1'b1;
          end
          `PMH_CMD_ON: begin
            s_next.level = s_reg.saved;
            s_next.on = 1'b1;
            s_next.fine_act = 1'b0;
          end
          `PMH_CMD_OFF: begin
            s_next.level = 3'h0;
            s_next.on = 1'b0;
            s_next.fine_act = 1'b0;
          end
          `PMH_CMD_TOGGLE: begin
            s_next.level = s_reg.on ? 3'h0 : s_reg.saved;
            s_next.on = ~s_reg.on;
            s_next.fine_act = 1'b0;
          end
          `PMH_CMD_FINE: begin
            s_next.fine = (s_reg.pay_lo[8:0] > `PMH_FINE_FULL) ? `PMH_FINE_FULL
                          : s_reg.pay_lo[8:0];
            s_next.fine_act = 1'b1;
            s_next.on = 1'b1;
          end
          `PMH_CMD_READ, `PMH_CMD_RD_FINE: begin
            s_next.level = s_reg.level;
          end
          `PMH_CMD_IO_SET, `PMH_CMD_IO_CLR: begin
            if (s_reg.profile == `PMH_PROF_MOTOR || s_reg.profile == `PMH_PROF_DIM) begin
              s_next.refused = 1'b1;
            end else if (s_reg.pay_lo[0]) begin
              s_next.gout1 = (code == `PMH_CMD_IO_SET);
            end else begin
              s_next.gout0 = (code == `PMH_CMD_IO_SET);
            end
          end
          `PMH_CMD_METER: begin
            // accepted whatever the destination, broadcast included
            s_next.edge_en = s_reg.pay_lo[0];
            s_next.interval = s_reg.pay_lo[23:8];
            s_next.conc = s_reg.cmd[23:16];
            s_next.rs = pmh_pkg::RS_HOLDOFF;
            s_next.slots = s_reg.node;
            s_next.slot_cnt = 32'h0;
            s_next.unit_cnt = 32'h0;
            s_next.per_cnt = 16'h0;
            s_next.want = 1'b0;
          end
          default: s_next.refused = 1'b1;
        endcase
      end
      // answers reflect the state after the command
      if (code == `PMH_CMD_FINE || code == `PMH_CMD_RD_FINE) begin
        s_next.ans_lo = {23'h0, s_next.fine};
      end else if (code >= `PMH_CMD_SET && code <= `PMH_CMD_TOGGLE) begin
        s_next.ans_lo = {16'h0, 5'h0, s_next.saved, 5'h0, s_next.level};
      end
    end

    // interval timer; zero interval never ticks
    if (s_reg.rs != pmh_pkg::RS_OFF && s_reg.interval != 16'h0) begin
      if (s_reg.unit_cnt == 32'(UNIT_CYCLES - 1)) begin
        s_next.unit_cnt = 32'h0;
        if (s_reg.per_cnt == s_reg.interval - 16'h1) begin
          s_next.per_cnt = 16'h0;
          tick = 1'b1;
        end else begin
          s_next.per_cnt = s_reg.per_cnt + 16'h1;
        end
      end else begin
        s_next.unit_cnt = s_reg.unit_cnt + 32'h1;
      end
    end
    // edge-only nodes keep no timer running, only the pin edge matters
    trig = tick | (s_reg.edge_en & fall);

    // report sequencer
    case (s_reg.rs)
      pmh_pkg::RS_OFF: begin
        s_next.want = 1'b0;
      end
      pmh_pkg::RS_HOLDOFF: begin
        if (trig) begin
          s_next.want = 1'b1;
        end
        if (s_reg.slots == 8'h0) begin
          s_next.rs = pmh_pkg::RS_RUN;
        end else if (s_reg.slot_cnt == 32'(SLOT_CYCLES - 1)) begin
          s_next.slot_cnt = 32'h0;
          s_next.slots = s_reg.slots - 8'h1;
        end else begin
          s_next.slot_cnt = s_reg.slot_cnt + 32'h1;
        end
      end
      pmh_pkg::RS_RUN: begin
        if (ack) begin
          s_next.rep_pend = 1'b0;
        end
        // a new report taken in the ack cycle stays pending
        if ((trig || s_reg.want) && (!s_reg.rep_pend || ack)) begin
          s_next.rep_pend = 1'b1;
          s_next.want = 1'b0;
          s_next.rep_lo = {7'h0, s_reg.gout1, 7'h0, pif.pin,
                           7'h0, s_reg.in1_s2, 7'h0, s_reg.in0_s2};
          s_next.rep_hi = {6'h0, CONV_ONE, 6'h0, CONV_ZERO};
        end else if (trig) begin
          s_next.want = 1'b1;
        end
      end
      default: s_next.rs = pmh_pkg::RS_OFF;
    endcase
    if (ack && s_reg.rs != pmh_pkg::RS_RUN) begin
      s_next.rep_pend = 1'b0;
    end

    // lamp pulse on each acknowledged report
    if (ack) begin
      s_next.led = 1'b1;
      s_next.led_cnt = 32'(BLINK_CYCLES - 1);
    end else if (s_reg.led_cnt != 32'h0) begin
      s_next.led_cnt = s_reg.led_cnt - 32'h1;
    end else begin
      s_next.led = 1'b0;
    end
  end

  // ----------------------------------------
  // state register
  // ----------------------------------------
  always_ff @(posedge MCLK or posedge RESET) begin
    if (RESET) begin
      s_reg <= '0; // saved level 0 stands for nothing saved
    end else begin
      s_reg <= s_next;
    end
  end

  // ----------------------------------------
  // dimming generator
  // ----------------------------------------
  assign pif.use_pwm = (s_reg.profile == `PMH_PROF_DIM);
  assign pif.io_level = s_reg.gout0;
  assign pif.duty = !s_reg.on ? 9'h000 : s_reg.fine_act ? s_reg.fine : lvl_duty(s_reg.level);

  pmh_pwm u_pwm (
    .clk(MCLK),
    .rst(RESET),
    .pw(pif.gen)
  );

  // outputs from flip-flops; the three ready signals are decoded from them
  assign S_AXI_AWREADY = ~s_reg.aw_got & ~s_reg.bvalid;
  assign S_AXI_WREADY = ~s_reg.w_got & ~s_reg.bvalid;
  assign S_AXI_BVALID = s_reg.bvalid;
  assign S_AXI_BRESP = s_reg.bresp;
  assign S_AXI_ARREADY = ~s_reg.rvalid;
  assign S_AXI_RVALID = s_reg.rvalid;
  assign S_AXI_RDATA = s_reg.rdata;
  assign S_AXI_RRESP = s_reg.rresp;
  assign GENERAL_OUTPUT_ZERO = pif.pin;
  assign GENERAL_OUTPUT_ONE = s_reg.gout1;
  assign NVM_WRITE = s_reg.nvm_we;
  assign NVM_LEVEL = s_reg.saved;
  assign REPORT_PENDING = s_reg.rep_pend;
  assign STATUS_LAMP = s_reg.led;
endmodule : pmh_top
`default_nettype wire

// ===== sim/pmh_sensor.sv
`timescale 1ns/100ps
`default_nettype none
// pins seen from the host side; input zero idles high on its pull-up
module pmh_sensor (
  input wire logic clk, // system clock
  output logic in0, // input zero pin
  output logic in1, // input one pin
  output logic [9:0] c0, // conversion zero
  output logic [9:0] c1 // conversion one
);
  // idle levels from time zero so the synchronisers never see x
  initial {in0, in1, c0, c1} = {2'b11, 20'h00000};
  // node assumed awake already, so the pull low comes straight away
  task automatic fall(input logic [9:0] a, input logic [9:0] b);
    @(posedge clk);
    c0 <= a;
    c1 <= b;
    in0 <= 1'b0;
    repeat (8) @(posedge clk);
    in0 <= 1'b1;
  endtask : fall
endmodule : pmh_sensor
`default_nettype wire

// ===== sim/pmh_chk.sv
`timescale 1ns/100ps
`default_nettype none
module pmh_chk (
  input wire logic MCLK, // clock
  input wire logic RESET, // reset
  input wire logic S_AXI_AWREADY, // aw ready
  input wire logic S_AXI_BVALID, // b valid
  input wire logic S_AXI_BREADY, // b ready
  input wire logic S_AXI_ARREADY, // ar ready
  input wire logic S_AXI_RVALID, // r valid
  input wire logic S_AXI_RREADY, // r ready
  input wire logic NVM_WRITE, // save strobe
  input wire logic [2:0] NVM_LEVEL, // saved level
  input wire logic REPORT_PENDING, // report waiting
  input wire logic STATUS_LAMP // lamp
);
  // one domain, so clock and reset are given once
  default clocking @(posedge MCLK);
  endclocking
  default disable iff (RESET);
  a_b_clears: assert property (S_AXI_BVALID && S_AXI_BREADY |=> !S_AXI_BVALID) else $error("b stuck");
  a_r_clears: assert property (S_AXI_RVALID && S_AXI_RREADY |=> !S_AXI_RVALID) else $error("r stuck");
  a_aw_blocked: assert property (S_AXI_BVALID |-> !S_AXI_AWREADY) else $error("aw open");
  a_ar_blocked: assert property (S_AXI_RVALID |-> !S_AXI_ARREADY) else $error("ar open");
  a_nvm_pulse: assert property (NVM_WRITE |=> !NVM_WRITE) else $error("save too long");
  a_nvm_range: assert property (NVM_WRITE |-> NVM_LEVEL <= 3'h5) else $error("level high");
  a_lamp_ack: assert property ($rose(STATUS_LAMP) |-> $past(REPORT_PENDING)) else $error("lamp");
  a_lamp_holds: assert property ($rose(STATUS_LAMP) |=> STATUS_LAMP) else $error("blink");
  c_save: cover property (NVM_WRITE);
  c_sent: cover property (REPORT_PENDING ##1 !REPORT_PENDING);
  c_lamp: cover property ($rose(STATUS_LAMP));
endmodule : pmh_chk
bind pmh_top pmh_chk pmh_chk_inst (.*);
`default_nettype wire

// ===== sim/test_pwm_metering_command_handler.sv
`timescale 1ns/100ps
`default_nettype none
`include "pmh_map.svh"
module test_pwm_metering_command_handler;
  logic MCLK = 1'b0, RESET = 1'b1, S_AXI_AWVALID = 1'b0, S_AXI_WVALID = 1'b0;
  logic S_AXI_BREADY = 1'b0, S_AXI_ARVALID = 1'b0, S_AXI_RREADY = 1'b0;
  logic [7:0] S_AXI_AWADDR = 8'h00, S_AXI_ARADDR = 8'h00;
  logic [31:0] S_AXI_WDATA = 32'h0, S_AXI_RDATA, d, rs = 32'h34de47c0;
  logic [3:0] S_AXI_WSTRB = 4'hf;
  logic S_AXI_AWREADY, S_AXI_WREADY, S_AXI_BVALID, S_AXI_ARREADY, S_AXI_RVALID;
  logic [1:0] S_AXI_BRESP, S_AXI_RRESP, r;
  logic GENERAL_INPUT_ZERO, GENERAL_INPUT_ONE, GENERAL_OUTPUT_ZERO, GENERAL_OUTPUT_ONE;
  logic NVM_WRITE, REPORT_PENDING, STATUS_LAMP;
  logic [9:0] CONV_ZERO, CONV_ONE, c0, c1;
  logic [2:0] NVM_LEVEL;
  logic [8:0] v;
  int bad_count = 0, checks_done = 0, n;
  // coarse steps: command low byte, then applied level (high nibble) and saved level
  logic [7:0] tc [13] = '{8'h33, 8'h30, 8'h31, 8'h31, 8'h31, 8'h32, 8'h34,
    8'h33, 8'h36, 8'h36, 8'h35, 8'h30, 8'h32};
  logic [7:0] te [13] = '{8'h00, 8'h33, 8'h44, 8'h55, 8'h55, 8'h44, 8'h04,
    8'h44, 8'h04, 8'h44, 8'h44, 8'h00, 8'h00};
  pmh_top #(.UNIT_CYCLES(20), .SLOT_CYCLES(4), .BLINK_CYCLES(3)) pmh_top_inst (.*);
  pmh_sensor pmh_sensor_inst (.clk(MCLK), .in0(GENERAL_INPUT_ZERO), .in1(GENERAL_INPUT_ONE),
    .c0(CONV_ZERO), .c1(CONV_ONE));
  // 8 ns period
  initial forever #4 MCLK = ~MCLK;
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction : lfsr
  // coarse answer: byte 0 applied level, byte 1 saved level
  function automatic logic [31:0] coarse(input logic [7:0] e);
    return {16'h0000, 5'h00, e[2:0], 5'h00, e[6:4]};
  endfunction : coarse
  // high counts per 256 for each coarse level: 0, 1/256, 1/64, 1/16, 1/4, all
  function automatic int lvl_cnt(input logic [2:0] l);
    return (l == 3'h5) ? 256 : (l == 3'h0) ? 0 : 1 << (2 * (l - 3'h1));
  endfunction : lvl_cnt
  // counts the dimming pin high over one full modulation period
  task automatic hi_count();
    n = 0;
    repeat (256) begin
      @(posedge MCLK);
      n += int'(GENERAL_OUTPUT_ZERO === 1'b1);
    end
  endtask : hi_count
  task automatic chk(input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      bad_count++;
      $display("[ERR] t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask : chk
  task automatic to();
    bad_count++;
    $display("[ERR] t=%0t wait ran out exp=%h got=%h", $time, 1'b1, 1'b0);
    wrap_up();
  endtask : to
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : wrap_up
  // bready rides along with the request, so the answer is taken when first seen
  task automatic wr(input logic [7:0] a, input logic [31:0] x);
    int k = 0;
    @(posedge MCLK);
    {S_AXI_AWADDR, S_AXI_WDATA} <= {a, x};
    {S_AXI_AWVALID, S_AXI_WVALID, S_AXI_BREADY} <= 3'b111;
    do begin
      @(posedge MCLK);
      if (S_AXI_AWREADY) S_AXI_AWVALID <= 1'b0;
      if (S_AXI_WREADY) S_AXI_WVALID <= 1'b0;
      k++;
    end while (!S_AXI_BVALID && k < 50);
    S_AXI_BREADY <= 1'b0;
    r = S_AXI_BRESP;
    if (k >= 50) to();
  endtask : wr
  task automatic rd(input logic [7:0] a);
    int k = 0;
    @(posedge MCLK);
    {S_AXI_ARADDR, S_AXI_ARVALID, S_AXI_RREADY} <= {a, 2'b11};
    do begin
      @(posedge MCLK);
      if (S_AXI_ARREADY) S_AXI_ARVALID <= 1'b0;
      k++;
    end while (!S_AXI_RVALID && k < 50);
    {d, r} = {S_AXI_RDATA, S_AXI_RRESP};
    S_AXI_RREADY <= 1'b0;
    if (k >= 50) to();
  endtask : rd
  task automatic cmd(input logic [15:0] c, input logic [7:0] s, input logic [31:0] p,
    input logic [1:0] f);
    wr(`PMH_OFF_CMD, {8'h00, s, c});
    wr(`PMH_OFF_PAY_LO, p);
    // profile first: go is judged against the profile already held
    wr(`PMH_OFF_CTRL, {30'h0, f});
    wr(`PMH_OFF_CTRL, {23'h0, 1'b1, 6'h00, f});
  endtask : cmd
  // main sequence
  initial begin
    repeat (20) @(posedge MCLK);
    RESET <= 1'b0;
    rd(`PMH_OFF_STATUS);
    chk(32'h0, d);
    rd(8'h3c);
    chk(32'h3, {30'h0, r});
    chk(32'h0, d);
    wr(8'h3c, 32'h1);
    chk(32'h3, {30'h0, r});
    $display("done: bus map");
    for (int i = 0; i < 13; i++) begin
      cmd({8'h00, tc[i]}, 8'h00, (i == 1) ? 32'h3 : 32'h0, `PMH_PROF_DIM);
      rd(`PMH_OFF_ANS_LO);
      chk(coarse(te[i]), d);
      chk({29'h0, te[i][2:0]}, {29'h0, NVM_LEVEL});
      hi_count();
      chk(lvl_cnt(te[i][6:4]), n);
    end
    $display("done: coarse");
    cmd(`PMH_CMD_RD_FINE, 8'h00, 32'h0, `PMH_PROF_DIM);
    rd(`PMH_OFF_ANS_LO);
    chk(32'h0, {23'h0, d[8:0]});
    for (int k = 0; k < 3; k++) begin
      v = (k == 0) ? {1'b0, rs[7:0]} : (k == 1) ? `PMH_FINE_FULL : 9'h000;
      rs = lfsr(rs);
      cmd(`PMH_CMD_FINE, 8'h00, {23'h0, v}, `PMH_PROF_DIM);
      rd(`PMH_OFF_ANS_LO);
      chk({23'h0, v}, {23'h0, d[8:0]});
      hi_count();
      chk({23'h0, v}, n);
    end
    $display("done: fine");
    cmd(`PMH_CMD_SET, 8'h00, 32'h3, `PMH_PROF_NONE);
    rd(`PMH_OFF_STATUS);
    chk(32'h1, {31'h0, d[1]});
    cmd(`PMH_CMD_IO_SET, 8'h00, 32'h1, `PMH_PROF_DIM);
    rd(`PMH_OFF_STATUS);
    chk(32'h1, {31'h0, d[1]});
    $display("done: refusal");
    wr(`PMH_OFF_NODE, 32'h2);
    cmd(`PMH_CMD_IO_SET, 8'h00, 32'h1, `PMH_PROF_METER);
    cmd(`PMH_CMD_IO_SET, 8'h00, 32'h0, `PMH_PROF_METER);
    @(posedge MCLK);
    chk(32'h3, {30'h0, GENERAL_OUTPUT_ONE, GENERAL_OUTPUT_ZERO});
    cmd(`PMH_CMD_METER, 8'h5a, 32'h1, `PMH_PROF_METER);
    rd(`PMH_OFF_REP_HDR);
    chk(32'h005a0041, d);
    repeat (20) @(posedge MCLK);
    {c1, c0} = {rs[25:16], rs[9:0]};
    rs = lfsr(rs);
    pmh_sensor_inst.fall(c0, c1);
    for (n = 0; n < 200 && REPORT_PENDING !== 1'b1; n++) @(posedge MCLK);
    chk(32'h1, {31'h0, REPORT_PENDING});
    rd(`PMH_OFF_REP_LO);
    chk(32'h01010100, d);
    rd(`PMH_OFF_REP_HI);
    chk({6'h00, c1, 6'h00, c0}, d);
    wr(`PMH_OFF_REP_ACK, 32'h1);
    chk(32'h2, {30'h0, STATUS_LAMP, REPORT_PENDING});
    $display("done: edge report");
    cmd(`PMH_CMD_METER, 8'hff, 32'h100, `PMH_PROF_METER);
    rd(`PMH_OFF_REP_HDR);
    chk(32'h00ff0041, d);
    for (n = 0; n < 200 && REPORT_PENDING !== 1'b1; n++) @(posedge MCLK);
    chk(32'h1, {31'h0, REPORT_PENDING});
    wr(`PMH_OFF_REP_ACK, 32'h1);
    $display("done: periodic report");
    wrap_up();
  end
endmodule : test_pwm_metering_command_handler
`default_nettype wire
